// file: hda_pkg.sv
// hda_pkg: register indices, field positions, reset values and timing for the hall angle decoder
// assumes: included before hda_hall_filter and hda_top, 32-bit apb data, one aligned word per register
`default_nettype none

package hda_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_MODE     = 8'h33;  // sensor_mode_config
  localparam logic [7:0] IDX_POS_0    = 8'h34;  // sector_position_0_60
  localparam logic [7:0] IDX_POS_1    = 8'h35;  // sector_position_120_180
  localparam logic [7:0] IDX_POS_2    = 8'h36;  // sector_position_240_300
  localparam logic [7:0] IDX_OFFSETS  = 8'h37;  // angle_offsets
  localparam logic [7:0] IDX_MAX_STEP = 8'h38;  // max_angle_step
  localparam logic [7:0] IDX_ELEC     = 8'h39;  // electrical_angle_result
  localparam logic [7:0] IDX_MECH     = 8'h3A;  // mechanical_angle_result

  // mode register field positions
  localparam int MODE_POL_BIT    = 0;
  localparam int MODE_SYNC_BIT   = 4;
  localparam int MODE_INTERP_BIT = 8;
  localparam int MODE_DIR_BIT    = 12;
  localparam int MODE_BLANK_LSB  = 16;
  localparam int MODE_BLANK_MSB  = 27;
  localparam logic [31:0] MODE_WR_MASK = 32'h0FFF_1111;  // writable mode bits

  // values after reset
  localparam logic [31:0] RST_MODE     = 32'h0000_0000;
  localparam logic [31:0] RST_POS_0    = 32'h2AAB_0000;  // 60 deg : 0 deg
  localparam logic [31:0] RST_POS_1    = 32'h8000_5555;  // 180 deg : 120 deg
  localparam logic [31:0] RST_POS_2    = 32'hD555_AAAB;  // 300 deg : 240 deg
  localparam logic [31:0] RST_OFFSETS  = 32'h0000_0000;
  localparam logic [15:0] RST_MAX_STEP = 16'h2AAA;       // one sixth of full scale

  // timing: blanking unit and clock period in ns
  localparam int unsigned BLANK_UNIT_NS = 10;
  localparam int unsigned CLK_PERIOD_NS = 25;

  // decoded mode fields
  typedef struct packed {
    logic [11:0] blank;   // blanking length in 10 ns units
    logic        dir;     // reverse angle progression
    logic        interp;  // interpolation on
    logic        sync;    // sample on pwm strobe only
    logic        pol;     // invert hall inputs
  } hda_mode_t;

endpackage : hda_pkg

`default_nettype wire

// file: hda_hall_filter.sv
// hda_hall_filter: synchronises the three hall pins, applies blanking and optional pwm-synchronous sampling
// assumes: hall pins are asynchronous, pwm_sample is a one-cycle strobe on pclk
`default_nettype none
`timescale 1ns/1ps

module hda_hall_filter
  import hda_pkg::*;
(
  input  wire logic       pclk,         // system clock
  input  wire logic       presetn,      // async reset, active low
  input  wire logic       ce,           // clock enable
  input  wire logic [2:0] hall_pins,    // raw hall inputs
  input  wire logic       pwm_sample,   // pwm cycle sample strobe
  input  var  hda_mode_t  mode,         // mode fields
  output logic      [2:0] hall_state,   // accepted hall levels, polarity applied
  output logic            hall_edge     // pulse when hall_state changed
);

  logic [2:0]  sync1_reg;   // first stage, read only by second
  logic [2:0]  sync2_reg;   // second stage
  logic [2:0]  sync3_reg;   // third stage
  logic [2:0]  agreed_reg;  // last level where stages two and three agreed
  logic [2:0]  level_reg;   // accepted level
  logic [15:0] blank_ns_reg;  // ns elapsed since last accepted change
  logic [15:0] blank_ns;    // required blanking in ns
  logic        blank_done;  // blanking over
  logic        accept;      // take a new level this cycle
  logic [2:0]  agreed_next;  // per-bit agreed level

  // three-flop synchroniser per hall line
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
        sync3_reg[i] <= 1'b0;
      end else if (ce) begin
        sync1_reg[i] <= hall_pins[i];
        sync2_reg[i] <= sync1_reg[i];
        sync3_reg[i] <= sync2_reg[i];
      end
    end
    // a bit changes only once stages two and three agree
    assign agreed_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : agreed_reg[i];
  end

  // hold the agreed level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      agreed_reg <= 3'h0;
    end else if (ce) begin
      agreed_reg <= agreed_next;
    end
  end

  assign blank_ns   = 16'(mode.blank) * 16'(BLANK_UNIT_NS);
  assign blank_done = (blank_ns_reg >= blank_ns);
  assign accept     = (agreed_reg != level_reg) && blank_done && (!mode.sync || pwm_sample);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_ns_reg <= 16'hFFFF;
    end else if (ce) begin
      if (accept) begin
        blank_ns_reg <= 16'h0000;  // restart after each accepted change
      end else if (!blank_done) begin
        blank_ns_reg <= blank_ns_reg + 16'(CLK_PERIOD_NS);
      end
    end
  end

  // accepted level and change pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 3'h0;
      hall_edge <= 1'b0;
    end else if (ce) begin
      hall_edge <= accept;
      if (accept) begin
        level_reg <= agreed_reg;
      end
    end
  end

  assign hall_state = mode.pol ? ~level_reg : level_reg;

  // pwm-synchronous mode only changes on a strobe
  property sync_gate_p;
    @(posedge pclk) disable iff (!presetn)
      hall_edge && ce && $past(ce) |-> !$past(mode.sync) || $past(pwm_sample);
  endproperty
  sync_sample_gate_a : assert property (sync_gate_p) else $error("hall change outside pwm strobe");

  // no two accepted changes closer than the blanking time
  blank_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
      ce && accept |-> 32'(blank_ns_reg) >= 32'(mode.blank) * BLANK_UNIT_NS)
    else $error("hall change inside blanking time");

endmodule : hda_hall_filter

`default_nettype wire

// file: hda_top.sv
// hda_top: digital hall angle decoder with apb register access
// assumes: apb master on pclk, hall pins asynchronous, pwm_sample a one-cycle strobe from the pwm engine
//
// Register access over APB was left to the implementer.
`default_nettype none
`timescale 1ns/1ps

module hda_top
  import hda_pkg::*;
(
  input  wire logic        pclk,        // system clock, 40 MHz
  input  wire logic        presetn,     // async reset, active low
  input  wire logic        ce,          // clock enable, freezes state when low
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb access phase
  input  wire logic        pwrite,      // apb write
  input  wire logic [11:0] paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error on unmapped address
  input  wire logic  [2:0] hall_pins,   // hall sensor inputs
  input  wire logic        pwm_sample,  // pwm cycle sample strobe
  output logic      [15:0] phi_e_out,   // electrical angle for the control loop
  output logic      [15:0] phi_m_out    // mechanical angle for the control loop
);

  // software registers
  logic [31:0] mode_reg;       // sensor_mode_config
  logic [31:0] pos_reg [3];    // sector position pairs
  logic [31:0] offsets_reg;    // angle_offsets
  logic [15:0] max_step_reg;   // max_angle_step
  hda_mode_t   mode;           // decoded mode fields

  // hall path
  logic  [2:0] hall_state;     // filtered hall level
  logic        hall_edge;      // filtered change pulse
  logic  [2:0] sector;         // sector from hall code
  logic        sector_ok;      // code is one of the six legal ones
  logic  [2:0] idx_next;       // sector after direction mapping
  logic  [2:0] idx_reg;        // current sector index
  logic  [2:0] idx_inc;        // index one sector ahead
  logic [15:0] pos_sel;        // calibration position of current sector
  logic        fwd_reg;        // last transition went forward
  logic [23:0] period_cnt_reg; // cycles since last transition
  logic [23:0] period_reg;     // length of previous sector in cycles
  logic [24:0] acc_reg;        // rate accumulator
  logic [24:0] acc_sum;        // accumulator plus step
  logic [15:0] offs_reg;       // interpolated advance past edge
  logic [15:0] interp_pos;     // position plus advance, minus it when the last transition went backward
  logic [15:0] raw_reg;        // raw electrical angle
  logic [15:0] interp_reg;     // interpolated electrical angle
  logic [15:0] mech_reg;       // mechanical angle

  // apb decode
  logic        in_range;       // address in the upper bits is zero
  logic        mapped;         // address hits a register
  logic        loaded_reg;     // read data latched, transfer may end
  logic        wr_take;        // write completes this edge
  logic [31:0] rd_mux;         // read data before the flop

  assign mode = '{blank:  mode_reg[MODE_BLANK_MSB:MODE_BLANK_LSB],
                  dir:    mode_reg[MODE_DIR_BIT],
                  interp: mode_reg[MODE_INTERP_BIT],
                  sync:   mode_reg[MODE_SYNC_BIT],
                  pol:    mode_reg[MODE_POL_BIT]};

  // hall synchroniser, blanking and sampling
  hda_hall_filter hda_hall_filter_i (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .hall_pins  (hall_pins),
    .pwm_sample (pwm_sample),
    .mode       (mode),
    .hall_state (hall_state),
    .hall_edge  (hall_edge)
  );

  // address decode
  assign in_range = (paddr[11:10] == 2'b00);
  always_comb begin
    mapped = 1'b0;
    rd_mux = 32'h0000_0000;
    if (in_range) begin
      unique case (paddr[9:2])
        IDX_MODE:     begin mapped = 1'b1; rd_mux = mode_reg; end
        IDX_POS_0:    begin mapped = 1'b1; rd_mux = pos_reg[0]; end
        IDX_POS_1:    begin mapped = 1'b1; rd_mux = pos_reg[1]; end
        IDX_POS_2:    begin mapped = 1'b1; rd_mux = pos_reg[2]; end
        IDX_OFFSETS:  begin mapped = 1'b1; rd_mux = offsets_reg; end
        IDX_MAX_STEP: begin mapped = 1'b1; rd_mux = {16'h0000, max_step_reg}; end
        IDX_ELEC:     begin mapped = 1'b1; rd_mux = {interp_reg, raw_reg}; end
        IDX_MECH:     begin mapped = 1'b1; rd_mux = {16'h0000, mech_reg}; end
        default:      begin mapped = 1'b0; rd_mux = 32'h0000_0000; end
      endcase
    end
  end

  // apb answers in the first access cycle unless the clock enable is low
  // a setup cycle that met a low clock enable costs one extra access cycle for its data
  assign pready  = ce && loaded_reg;
  assign pslverr = psel && penable && !mapped;
  assign wr_take = psel && penable && pwrite && pready && mapped;

  // read data captured at the first enabled edge of each transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata     <= 32'h0000_0000;
      loaded_reg <= 1'b0;
    end else if (ce) begin
      if (psel && !loaded_reg) begin
        // zero for writes and unmapped reads
        prdata     <= pwrite ? 32'h0000_0000 : rd_mux;
        loaded_reg <= 1'b1;
      end else if (!psel || penable) begin
        // transfer ended or bus idle: next transfer loads afresh
        loaded_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg     <= RST_MODE;
      pos_reg[0]   <= RST_POS_0;
      pos_reg[1]   <= RST_POS_1;
      pos_reg[2]   <= RST_POS_2;
      offsets_reg  <= RST_OFFSETS;
      max_step_reg <= RST_MAX_STEP;
    end else if (wr_take) begin
      unique case (paddr[9:2])
        IDX_MODE:     mode_reg     <= pwdata & MODE_WR_MASK;
        IDX_POS_0:    pos_reg[0]   <= pwdata;
        IDX_POS_1:    pos_reg[1]   <= pwdata;
        IDX_POS_2:    pos_reg[2]   <= pwdata;
        IDX_OFFSETS:  offsets_reg  <= pwdata;
        IDX_MAX_STEP: max_step_reg <= pwdata[15:0];
        default:      ;  // result registers are read only
      endcase
    end
  end

  // hall code to sector: 001,011,010,110,100,101 give 0..5
  always_comb begin
    sector_ok = 1'b1;
    unique case (hall_state)
      3'h1:    sector = 3'h0;
      3'h3:    sector = 3'h1;
      3'h2:    sector = 3'h2;
      3'h6:    sector = 3'h3;
      3'h4:    sector = 3'h4;
      3'h5:    sector = 3'h5;
      default: begin sector = 3'h0; sector_ok = 1'b0; end
    endcase
  end

  // reversed direction mirrors the sector order
  assign idx_next = (mode.dir && sector != 3'h0) ? 3'(3'h6 - sector) : sector;
  assign idx_inc  = (idx_reg == 3'h5) ? 3'h0 : 3'(idx_reg + 3'h1);

  // calibration position for the current sector
  assign pos_sel = idx_reg[0] ? pos_reg[idx_reg[2:1]][31:16] : pos_reg[idx_reg[2:1]][15:0];

  // sector tracking and rate measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_reg        <= 3'h0;
      fwd_reg        <= 1'b1;
      period_cnt_reg <= 24'h000000;
      period_reg     <= 24'h000000;
    end else if (ce) begin
      if (sector_ok && idx_next != idx_reg) begin
        idx_reg        <= idx_next;
        fwd_reg        <= (idx_next == idx_inc);
        // rate from the sector just left
        period_reg     <= period_cnt_reg;
        period_cnt_reg <= 24'h000000;
      end else if (period_cnt_reg != 24'hFFFFFF) begin
        period_cnt_reg <= period_cnt_reg + 24'h000001;
      end
    end
  end

  assign acc_sum = acc_reg + {9'h000, max_step_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg  <= 25'h0000000;
      offs_reg <= 16'h0000;
    end else if (ce) begin
      if (sector_ok && idx_next != idx_reg) begin
        acc_reg  <= 25'h0000000;
        offs_reg <= 16'h0000;
      end else if (period_reg != 24'h000000 && offs_reg < max_step_reg) begin
        // advance stops at the maximum step
        if (acc_sum >= {1'b0, period_reg}) begin
          acc_reg  <= acc_sum - {1'b0, period_reg};
          offs_reg <= offs_reg + 16'h0001;
        end else begin
          acc_reg  <= acc_sum;
        end
      end
    end
  end

  assign interp_pos = fwd_reg ? 16'(pos_sel + offs_reg) : 16'(pos_sel - offs_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_reg    <= 16'h0000;
      interp_reg <= 16'h0000;
      mech_reg   <= 16'h0000;
    end else if (ce) begin
      raw_reg    <= 16'(pos_sel + offsets_reg[31:16]);
      // interpolated half follows raw when interpolation is off
      interp_reg <= mode.interp ? 16'(interp_pos + offsets_reg[31:16]) : 16'(pos_sel + offsets_reg[31:16]);
      mech_reg   <= 16'(pos_sel + offsets_reg[15:0]);
    end
  end

  assign phi_e_out = interp_reg;
  assign phi_m_out = mech_reg;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  mode_write_a : assert property (
      wr_take && paddr[9:2] == IDX_MODE |=> mode_reg == ($past(pwdata) & MODE_WR_MASK))
    else $error("mode write not stored");

  raw_angle_a : assert property (
      ce && $past(ce) |-> raw_reg == 16'($past(pos_sel) + $past(offsets_reg[31:16])))
    else $error("raw angle differs from calibration position");

  mech_offset_a : assert property (
      ce && $past(ce) |-> mech_reg == 16'($past(pos_sel) + $past(offsets_reg[15:0])))
    else $error("mechanical angle offset wrong");

  step_limit_a : assert property (
      ce && $past(ce) && $past(offs_reg) >= $past(max_step_reg) |-> offs_reg <= $past(offs_reg))
    else $error("advance beyond maximum step");

  interp_off_a : assert property (
      ce && $past(ce) && !$past(mode.interp) |-> interp_reg == raw_reg)
    else $error("interpolated angle not raw when disabled");

  edge_restart_a : assert property (
      ce && sector_ok && idx_next != idx_reg |=> offs_reg == 16'h0000)
    else $error("advance not cleared at transition");

  rate_step_a : assert property (
      ce && $past(ce) && $past(period_reg) == 24'h000000 && !$past(idx_next != idx_reg)
      |-> offs_reg == $past(offs_reg))
    else $error("advance without a measured rate");

  direction_a : assert property (
      ce && mode.dir && sector_ok && sector != 3'h0 |-> idx_next == 3'(3'h6 - sector))
    else $error("direction mapping wrong");

  unmapped_err_a : assert property (
      psel && penable && (!in_range || paddr[9:2] < IDX_MODE || paddr[9:2] > IDX_MECH) |-> pslverr)
    else $error("unmapped access without error");

  mode_read_a : assert property (
      psel && penable && pready && !pwrite && in_range && paddr[9:2] == IDX_MODE |-> prdata == mode_reg)
    else $error("mode read data wrong");

  write_data_a : assert property (
      psel && penable && pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("read data not zero on write");

  illegal_hold_a : assert property (
      ce && !sector_ok |=> idx_reg == $past(idx_reg))
    else $error("sector moved on illegal hall code");

  interp_run_c : cover property (mode.interp && offs_reg == max_step_reg);
  sector_step_c : cover property (hall_edge ##[1:50] (idx_reg == 3'h1));
  mode_write_c : cover property (wr_take && paddr[9:2] == IDX_MODE);
  ce_wait_c : cover property (psel && penable && !pready);
  reverse_run_c : cover property (mode.dir && !fwd_reg && offs_reg != 16'h0000);

endmodule : hda_top

`default_nettype wire

// file: hda_hall_model.sv
// hda_hall_model: three digital hall sensors on the rotor, one code per electrical sector
// assumes: the bench sets the sector after a clock edge; flip models inverted sensor wiring
`default_nettype none
`timescale 1ns/1ps

module hda_hall_model (
  input  wire logic       pclk,       // bench clock, pins move on its edge
  input  wire logic [2:0] sector,     // rotor sector 0..5, 6 and 7 give the illegal codes
  input  wire logic       flip,       // inverted sensor wiring
  output logic      [2:0] hall_pins   // push-pull outputs, always driven
);
  logic [2:0] code;  // sensor code for the sector

  // sector to sensor code, one bit changes per sector step
  always_comb begin
    case (sector)
      3'd0: code = 3'b001;
      3'd1: code = 3'b011;
      3'd2: code = 3'b010;
      3'd3: code = 3'b110;
      3'd4: code = 3'b100;
      3'd5: code = 3'b101;
      3'd6: code = 3'b000;  // all sensors low, never seen on a healthy motor
      default: code = 3'b111;
    endcase
  end

  // push-pull sensors: pins always carry a level, never float
  always_ff @(posedge pclk) begin
    hall_pins <= code ^ {3{flip}};
  end
endmodule // hda_hall_model

`default_nettype wire

// file: hda_tb.sv
// hda_tb: self-checking bench for the hall angle decoder, apb tasks and a hall sensor model
// assumes: hda_pkg, hda_top and hda_hall_model compiled first; ce high except in the wait-state test
`default_nettype none
`timescale 1ns/1ps

module hda_tb
  import hda_pkg::*;
;
  localparam logic [15:0] EOFF = 16'h0030;  // electrical offset programmed
  localparam logic [15:0] MOFF = 16'h0005;  // mechanical offset programmed
  logic        pclk;          // 40 MHz clock
  logic        presetn;       // async reset, active low
  logic        ce;            // clock enable
  logic        psel;          // apb select
  logic        penable;       // apb access phase
  logic        pwrite;        // apb direction
  logic [11:0] paddr;         // apb byte address
  logic [31:0] pwdata;        // apb write data
  logic [31:0] prdata;        // apb read data
  logic        pready;        // apb ready
  logic        pslverr;       // apb error
  logic  [2:0] hall_pins;     // sensor outputs
  logic        pwm_sample;    // pwm sample strobe
  logic [15:0] phi_e_out;     // electrical angle output
  logic [15:0] phi_m_out;     // mechanical angle output
  logic  [2:0] sector;        // rotor sector for the model
  logic        flip;          // inverted sensor wiring
  int          mismatches;    // failed comparisons
  int          total_checks;  // comparisons made
  logic [31:0] d;             // last read data
  logic        e;             // last error flag
  logic [15:0] pos_v [6];     // programmed sector positions

  // free-running clock, 25 ns period
  always #12.5 pclk = ~pclk;

  hda_top hda_top_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hall_pins(hall_pins), .pwm_sample(pwm_sample),
    .phi_e_out(phi_e_out), .phi_m_out(phi_m_out)
  );

  hda_hall_model hda_hall_model_i (.pclk(pclk), .sector(sector), .flip(flip), .hall_pins(hall_pins));

  // compare and count, report at once on a miss
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, entered just after a clock edge; holds all until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // register read compared under a mask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 32'h0000_0000);
    chk(what, exp & mask, d & mask);
  endtask

  // move the rotor and let the pin-to-result latency pass
  task automatic hall(input logic [2:0] k);
    sector <= k;
    repeat (14) @(posedge pclk);
  endtask

  // raw electrical and mechanical angles for sector index k
  task automatic ang(input int k);
    rd_chk(IDX_ELEC, 32'h0000_FFFF, {16'h0000, pos_v[k] + EOFF}, "raw electrical angle");
    rd_chk(IDX_MECH, 32'h0000_FFFF, {16'h0000, pos_v[k] + MOFF}, "mechanical angle");
    chk("phi_m_out", {16'h0000, pos_v[k] + MOFF}, {16'h0000, phi_m_out});
  endtask

  // verdict, reached from the end of the tests or from the watchdog
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog: the tests take about 1050 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    $display("ERROR watchdog expected finish seen hang");
    mismatches++;
    give_verdict();
  end

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pwm_sample = 1'b0;
    sector = 3'd6;
    flip = 1'b0;
    mismatches = 0;
    total_checks = 0;
    pos_v = '{16'h0100, 16'h2000, 16'h4000, 16'h6000, 16'h8000, 16'hA000};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(IDX_MODE, 32'hFFFF_FFFF, RST_MODE, "mode reset");
    rd_chk(IDX_POS_0, 32'hFFFF_FFFF, RST_POS_0, "pos0 reset");
    rd_chk(IDX_POS_1, 32'hFFFF_FFFF, RST_POS_1, "pos1 reset");
    rd_chk(IDX_POS_2, 32'hFFFF_FFFF, RST_POS_2, "pos2 reset");
    rd_chk(IDX_OFFSETS, 32'hFFFF_FFFF, RST_OFFSETS, "offsets reset");
    rd_chk(IDX_MAX_STEP, 32'h0000_FFFF, {16'h0000, RST_MAX_STEP}, "max step reset");
    $display("test reset values done");
    apb(1'b1, IDX_MODE, 32'hFFFF_FFFF);
    rd_chk(IDX_MODE, 32'hFFFF_FFFF, MODE_WR_MASK, "mode writable bits");
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
    $display("test register access done");
    apb(1'b1, IDX_MODE, 32'h0000_0000);
    apb(1'b1, IDX_POS_0, {pos_v[1], pos_v[0]});
    apb(1'b1, IDX_POS_1, {pos_v[3], pos_v[2]});
    apb(1'b1, IDX_POS_2, {pos_v[5], pos_v[4]});
    apb(1'b1, IDX_OFFSETS, {EOFF, MOFF});
    // clock enable low across the setup and first three access cycles: the read must wait, then carry fresh data
    ce <= 1'b0;
    fork
      rd_chk(IDX_OFFSETS, 32'hFFFF_FFFF, {EOFF, MOFF}, "offsets read across ce low");
      begin
        repeat (4) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    $display("test clock enable done");
    for (int k = 0; k < 6; k++) begin
      hall(k[2:0]);
      ang(k);
    end
    apb(1'b1, IDX_MECH, 32'hFFFF_FFFF);
    ang(5);
    $display("test sector positions done");
    apb(1'b1, IDX_MODE, 32'h0000_1000);
    for (int k = 0; k < 6; k++) begin
      hall(k[2:0]);
      ang((6 - k) % 6);
    end
    $display("test direction done");
    apb(1'b1, IDX_MODE, 32'h0000_0001);
    flip <= 1'b1;
    hall(3'd2);
    ang(2);
    hall(3'd6);
    ang(2);
    flip <= 1'b0;
    apb(1'b1, IDX_MODE, 32'h0000_0010);
    $display("test polarity done");
    hall(3'd3);
    ang(2);
    pwm_sample <= 1'b1;
    @(posedge pclk);
    pwm_sample <= 1'b0;
    repeat (14) @(posedge pclk);
    ang(3);
    $display("test pwm sampling done");
    // blank field 100 gives 1000 ns, 40 cycles at 25 ns
    apb(1'b1, IDX_MODE, 32'h0064_0000);
    repeat (40) @(posedge pclk);
    hall(3'd4);
    ang(4);
    hall(3'd5);
    ang(4);
    repeat (40) @(posedge pclk);
    ang(5);
    $display("test blanking done");
    apb(1'b1, IDX_MODE, 32'h0000_0100);
    apb(1'b1, IDX_MAX_STEP, 32'h0000_0040);
    hall(3'd0);
    repeat (86) @(posedge pclk);
    hall(3'd1);
    repeat (86) @(posedge pclk);
    hall(3'd2);
    apb(1'b0, IDX_ELEC, 32'h0000_0000);
    chk("interp ramp below cap", 32'h1, {31'h0, d[31:16] != d[15:0] && (d[31:16] - d[15:0]) < 16'h0040});
    repeat (300) @(posedge pclk);
    rd_chk(IDX_ELEC, 32'hFFFF_FFFF, {pos_v[2] + EOFF + 16'h0040, pos_v[2] + EOFF}, "interp capped");
    chk("phi_e_out capped", {16'h0000, pos_v[2] + EOFF + 16'h0040}, {16'h0000, phi_e_out});
    $display("test interpolation done");
    give_verdict();
  end
endmodule // hda_tb

`default_nettype wire
